// *** include/swo_cfg.svh ***
// Constants for the sleep, watchdog and option control block
`ifndef SWO_CFG_SVH
`define SWO_CFG_SVH
`define SWO_OP_NOP 8'hFF
`define SWO_OP_STOP 8'h6F
`define SWO_OP_HALT 8'h7F
`define SWO_OP_WDT 8'h5F
`define SWO_OP_WDH 8'h4F
`define SWO_RESET_VECTOR 16'h000C
`define SWO_POR_EXTRA_CLKS 18
`define SWO_WDT_TIME_MS 10
`define SWO_CLK_MHZ 100
`define SWO_WDT_CYCLES (`SWO_WDT_TIME_MS * 1000 * `SWO_CLK_MHZ)
`define SWO_POR_TIME_MS 1
`define SWO_POR_CYCLES (`SWO_POR_TIME_MS * 1000 * `SWO_CLK_MHZ)
`define SWO_LOWNOISE_DIV 1
`define SWO_NORMAL_DIV 2
`define SWO_ADDR_W 11
`define SWO_ADDR_ZERO 11'h000
`define SWO_ADDR_ONE 11'h001
`define SWO_REG_CTRL 12'h000
`define SWO_REG_STATUS 12'h004
`define SWO_REG_OPT 12'h008
`define SWO_REG_PC 12'h00C
`define SWO_REG_PADDR 12'h010
`define SWO_CTRL_W 3
`define SWO_OPT_W 5
`define SWO_OPT_PROTECT 0
`define SWO_OPT_LOWNOISE 1
`define SWO_OPT_NOLATCH 2
`define SWO_OPT_PERMWDT 3
`define SWO_OPT_TESTDIS 4
`endif

// *** include/swo_pkg.sv ***
// Types for the sleep, watchdog and option control block
package swo_pkg;
    typedef enum logic [1:0] {
        SWO_RUN = 2'b00,
        SWO_HALT = 2'b01,
        SWO_STOP = 2'b10,
        SWO_RST = 2'b11
    } swo_state_e;
    typedef enum logic [2:0] {
        SWO_PM_NONE = 3'b000,
        SWO_PM_READ = 3'b001,
        SWO_PM_PROG = 3'b010,
        SWO_PM_VERIFY = 3'b011,
        SWO_PM_OPTION = 3'b100
    } swo_pmode_e;
endpackage

// *** core/swo_core.sv ***
// Sleep, watchdog, option bit and programming mode control
// Functional notes
// R01 - HALT gates CPU clock; oscillator, timers and IRQ0..3 keep running
// R02 - HALT ends only on a taken enabled interrupt; resume after HALT; code also leaves HALT for reset on watchdog timeout
// R03 - STOP halts clock and oscillator; released by low stop-recovery pin reset
// R04 - After stop-recovery release fetch starts at address 000C hex
// R05 - Stop-recovery release keeps port mode registers unchanged
// R06 - Low stop-recovery pin ends STOP even when pin is an output
// R07 - Software places NOP FFH before STOP 6F or HALT
// R08 - First 5FH enables watchdog, later ones clear it; never stoppable
// R09 - Watchdog timeout gives power-on reset: delay plus 18 clocks
// R10 - Watchdog opcode sets Z, clears S and V
// R11 - Software-enabled watchdog does not count in STOP
// R12 - 4FH lets watchdog count in HALT without clearing; else pauses
// R13 - 4FH has no effect before watchdog is enabled
// R14 - Permanent watchdog option: enabled from reset, runs in HALT, STOP
// R15 - Low-noise option bypasses divide-by-two, clock limited to 4 MHz
// R16 - ROM protect blocks external reads, keeps load ops, no low-noise; code: verify mode still drives data out, low-noise still applies
// R17 - Auto-latch-disable option disables all input auto latches
// R18 - Test-disable option refuses programming and test after power cycle
// R19 - Programming mode remaps pins to chip-enable, OE, mode, VPP, strobe
// R20 - Programming decode of read, program and verify by pin levels
// R21 - Option bit chosen by mode-select and OE levels during strobe
// R22 - High clear pin resets program address counter to zero
// R23 - Address clock pin advances program address counter by one
// R24 - Power-on and watchdog reset share one reset path and vector
//
// Decided for this implementation: the register offsets and the APB register port.
`include "swo_cfg.svh"
module swo_core #(
    parameter int WDT_CYCLES = `SWO_WDT_CYCLES,
    parameter int POR_CYCLES = `SWO_POR_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire logic [7:0] op_code,
    input wire logic irq_taken,
    input wire logic stop_recovery_pin,
    input wire logic oscillator_input_pin,
    input wire logic oscillator_input_hv,
    input wire logic port3_bit1,
    input wire logic port3_bit2,
    input wire logic program_mode_select_hv,
    input wire logic port3_bit3,
    input wire logic port0_bit2,
    input wire logic clear_pin,
    input wire logic address_clock_pin,
    output logic cpu_clk_en,
    output logic osc_en,
    output logic cpu_reset,
    output logic keep_port_modes,
    output logic [15:0] fetch_vector,
    output logic flag_set_z,
    output logic flag_clr_sv,
    output logic clk_div_two,
    output logic auto_latch_en,
    output logic ext_read_block,
    output logic [`SWO_ADDR_W-1:0] prog_addr,
    output logic prog_data_out_en,
    output logic prog_write_strobe
);
    swo_pkg::swo_state_e state_reg;
    swo_pkg::swo_pmode_e pmode;
    logic [1:0] srp_s, osc_s, oe_s, ms_s, msh_s, vpp_s, pgm_s, clr_s, ack_s, oh_s;
    logic ack_d;
    logic [`SWO_OPT_W-1:0] opt_reg;
    logic [`SWO_OPT_W-1:0] opt_live_reg;
    logic wdt_en_reg, wdh_reg, from_stop_reg;
    logic [31:0] wdt_cnt_reg, rst_cnt_reg;
    logic wdt_run, wdt_timeout, prog_ok;

    function automatic logic is_op(input logic [7:0] a, input logic [7:0] b);
        return op_valid && (a == b);
    endfunction

    // Two-flop synchronisers for every pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srp_s <= 2'b11; osc_s <= 2'b11; oe_s <= 2'b11; ms_s <= 2'b00; msh_s <= 2'b00;
            vpp_s <= 2'b00; pgm_s <= 2'b11; clr_s <= 2'b00; ack_s <= 2'b00; oh_s <= 2'b00;
        end else begin
            srp_s <= {srp_s[0], stop_recovery_pin};
            osc_s <= {osc_s[0], oscillator_input_pin};
            oe_s <= {oe_s[0], port3_bit1};
            ms_s <= {ms_s[0], port3_bit2};
            msh_s <= {msh_s[0], program_mode_select_hv};
            vpp_s <= {vpp_s[0], port3_bit3};
            pgm_s <= {pgm_s[0], port0_bit2};
            clr_s <= {clr_s[0], clear_pin};
            ack_s <= {ack_s[0], address_clock_pin};
            oh_s <= {oh_s[0], oscillator_input_hv};
        end
    end

    // Programming mode decode; test-disable uses value latched in the reset state
    assign prog_ok = !opt_reg[`SWO_OPT_TESTDIS]; // see R18
    always_comb begin
        pmode = swo_pkg::SWO_PM_NONE;
        if (prog_ok && !osc_s[1]) begin // see R19
            if (msh_s[1] && !oe_s[1] && pgm_s[1]) pmode = swo_pkg::SWO_PM_READ; // see R20
            else if (vpp_s[1] && ms_s[1] && oe_s[1] && !pgm_s[1]) pmode = swo_pkg::SWO_PM_PROG;
            else if (vpp_s[1] && !oe_s[1] && pgm_s[1]) pmode = swo_pkg::SWO_PM_VERIFY;
        end else if (prog_ok && oh_s[1] && vpp_s[1] && !pgm_s[1]) begin
            pmode = swo_pkg::SWO_PM_OPTION; // see R21
        end
    end

    // Option bits: one-time programmable, live copy applies at the next pass through the reset state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_live_reg <= '0;
        end else if (pmode == swo_pkg::SWO_PM_OPTION) begin
            if (msh_s[1] && oe_s[1]) opt_live_reg[`SWO_OPT_PROTECT] <= 1'b1; // see R21
            else if (!msh_s[1] && ms_s[1] && oe_s[1]) opt_live_reg[`SWO_OPT_LOWNOISE] <= 1'b1;
            else if (ms_s[1] && !oe_s[1]) opt_live_reg[`SWO_OPT_NOLATCH] <= 1'b1;
            else if (!ms_s[1] && oe_s[1]) opt_live_reg[`SWO_OPT_PERMWDT] <= 1'b1;
            else if (!ms_s[1] && !oe_s[1]) opt_live_reg[`SWO_OPT_TESTDIS] <= 1'b1;
        end
    end

    // Address counter for programming
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_addr <= `SWO_ADDR_ZERO;
            ack_d <= 1'b0;
        end else begin
            ack_d <= ack_s[1];
            if (clr_s[1]) prog_addr <= `SWO_ADDR_ZERO; // see R22
            else if (ack_s[1] && !ack_d) prog_addr <= prog_addr + `SWO_ADDR_ONE; // see R23
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_data_out_en <= 1'b0;
            prog_write_strobe <= 1'b0;
        end else begin
            prog_data_out_en <= (pmode == swo_pkg::SWO_PM_VERIFY) ||
                ((pmode == swo_pkg::SWO_PM_READ) && !opt_reg[`SWO_OPT_PROTECT]); // see R16
            prog_write_strobe <= (pmode == swo_pkg::SWO_PM_PROG); // see R20
        end
    end

    // Sleep and reset state machine
    assign wdt_run = wdt_en_reg && ((state_reg == swo_pkg::SWO_RUN) ||
        (state_reg == swo_pkg::SWO_HALT && (wdh_reg || opt_reg[`SWO_OPT_PERMWDT])) || // see R12
        (state_reg == swo_pkg::SWO_STOP && opt_reg[`SWO_OPT_PERMWDT])); // see R11 see R14
    assign wdt_timeout = wdt_run && (wdt_cnt_reg == 32'(WDT_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= swo_pkg::SWO_RST;
            rst_cnt_reg <= '0;
            from_stop_reg <= 1'b0;
            opt_reg <= '0;
        end else begin
            case (state_reg)
                swo_pkg::SWO_RUN: begin
                    if (wdt_timeout) state_reg <= swo_pkg::SWO_RST; // see R24
                    else if (is_op(op_code, `SWO_OP_STOP)) state_reg <= swo_pkg::SWO_STOP;
                    else if (is_op(op_code, `SWO_OP_HALT)) state_reg <= swo_pkg::SWO_HALT;
                    rst_cnt_reg <= '0;
                    from_stop_reg <= 1'b0;
                end
                swo_pkg::SWO_HALT: begin
                    if (wdt_timeout) state_reg <= swo_pkg::SWO_RST;
                    else if (irq_taken) state_reg <= swo_pkg::SWO_RUN; // see R02
                end
                swo_pkg::SWO_STOP: begin
                    if (wdt_timeout) begin
                        state_reg <= swo_pkg::SWO_RST;
                    end else if (!srp_s[1]) begin // see R03 see R06
                        state_reg <= swo_pkg::SWO_RST;
                        from_stop_reg <= 1'b1;
                    end
                end
                swo_pkg::SWO_RST: begin
                    opt_reg <= opt_live_reg;
                    if (rst_cnt_reg == 32'(POR_CYCLES + `SWO_POR_EXTRA_CLKS - 1)) begin // see R09
                        state_reg <= swo_pkg::SWO_RUN;
                    end
                    rst_cnt_reg <= rst_cnt_reg + 32'd1;
                end
                default: state_reg <= swo_pkg::SWO_RST;
            endcase
        end
    end

    // Watchdog enable, keep-in-halt and counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_en_reg <= 1'b0;
            wdh_reg <= 1'b0;
            wdt_cnt_reg <= '0;
        end else if (state_reg == swo_pkg::SWO_RST) begin
            wdt_en_reg <= opt_live_reg[`SWO_OPT_PERMWDT]; // see R14
            wdh_reg <= 1'b0;
            wdt_cnt_reg <= '0;
        end else begin
            if (state_reg == swo_pkg::SWO_RUN && is_op(op_code, `SWO_OP_WDT)) begin
                wdt_en_reg <= 1'b1; // see R08
                wdt_cnt_reg <= '0;
            end else if (wdt_run) begin
                wdt_cnt_reg <= wdt_cnt_reg + 32'd1;
            end
            if (state_reg == swo_pkg::SWO_RUN && wdt_en_reg && is_op(op_code, `SWO_OP_WDH))
                wdh_reg <= 1'b1; // see R13
        end
    end

    // Clock, reset and flag outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en <= 1'b0;
            osc_en <= 1'b1;
            cpu_reset <= 1'b1;
            keep_port_modes <= 1'b0;
            fetch_vector <= `SWO_RESET_VECTOR;
            flag_set_z <= 1'b0;
            flag_clr_sv <= 1'b0;
            clk_div_two <= 1'b1;
            auto_latch_en <= 1'b1;
            ext_read_block <= 1'b0;
        end else begin
            cpu_clk_en <= (state_reg == swo_pkg::SWO_RUN); // see R01
            osc_en <= (state_reg != swo_pkg::SWO_STOP); // see R03
            cpu_reset <= (state_reg == swo_pkg::SWO_RST); // see R24
            keep_port_modes <= from_stop_reg; // see R05
            fetch_vector <= `SWO_RESET_VECTOR; // see R04
            flag_set_z <= (state_reg == swo_pkg::SWO_RUN) && is_op(op_code, `SWO_OP_WDT); // see R10
            flag_clr_sv <= (state_reg == swo_pkg::SWO_RUN) && is_op(op_code, `SWO_OP_WDT);
            clk_div_two <= !opt_reg[`SWO_OPT_LOWNOISE]; // see R15
            auto_latch_en <= !opt_reg[`SWO_OPT_NOLATCH]; // see R17
            ext_read_block <= opt_reg[`SWO_OPT_PROTECT]; // see R16
        end
    end

    // APB slave, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable) begin
                case (paddr)
                    `SWO_REG_CTRL: prdata <= {29'd0, wdh_reg, wdt_en_reg, from_stop_reg};
                    `SWO_REG_STATUS: prdata <= {28'd0, pmode == swo_pkg::SWO_PM_NONE,
                        1'b0, state_reg};
                    `SWO_REG_OPT: prdata <= {22'd0, opt_live_reg, opt_reg};
                    `SWO_REG_PC: prdata <= wdt_cnt_reg;
                    `SWO_REG_PADDR: prdata <= {21'd0, prog_addr};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Steps of a STOP release through the recovery pin
    sequence s_stop_release;
        (state_reg == swo_pkg::SWO_STOP) && !srp_s[1] && !wdt_timeout;
    endsequence

    sequence s_recover_keep_ports;
        (state_reg == swo_pkg::SWO_RST) ##2 keep_port_modes;
    endsequence

    // Steps of a watchdog refresh and of a watchdog timeout
    sequence s_wdt_op;
        (state_reg == swo_pkg::SWO_RUN) && op_valid && (op_code == `SWO_OP_WDT);
    endsequence

    sequence s_reset_entry;
        (state_reg == swo_pkg::SWO_RST) ##1 cpu_reset;
    endsequence

    // CPU clock stops in HALT while the oscillator keeps running
    property p_halt_gate;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == swo_pkg::SWO_HALT) |=> (!cpu_clk_en && osc_en);
    endproperty
    a_halt_clock_gate: assert property (p_halt_gate) // see R01
        else $error("CPU clock not gated in HALT");

    // A taken interrupt ends HALT
    property p_halt_wake;
        @(posedge pclk) disable iff (!presetn)
        ((state_reg == swo_pkg::SWO_HALT) && irq_taken && !wdt_timeout) |=>
            (state_reg == swo_pkg::SWO_RUN);
    endproperty
    a_halt_irq_wake: assert property (p_halt_wake) // see R02
        else $error("Interrupt did not end HALT");

    // STOP stops both clock and oscillator
    property p_stop_osc;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == swo_pkg::SWO_STOP) |=> (!osc_en && !cpu_clk_en);
    endproperty
    a_stop_osc_off: assert property (p_stop_osc) // see R03
        else $error("Oscillator still enabled in STOP");

    // Recovery pin release goes through reset and keeps port modes
    property p_stop_wake;
        @(posedge pclk) disable iff (!presetn)
        s_stop_release |=> s_recover_keep_ports;
    endproperty
    a_stop_keep_ports: assert property (p_stop_wake) // see R05
        else $error("STOP release lost port modes");

    // Watchdog opcode enables and clears the counter
    property p_wdt_refresh;
        @(posedge pclk) disable iff (!presetn)
        s_wdt_op |=> (wdt_en_reg && (wdt_cnt_reg == '0));
    endproperty
    a_wdt_refresh_clear: assert property (p_wdt_refresh) // see R08
        else $error("Watchdog opcode did not enable and clear");

    // Watchdog opcode flag effects
    property p_wdt_flags;
        @(posedge pclk) disable iff (!presetn)
        s_wdt_op |=> (flag_set_z && flag_clr_sv);
    endproperty
    a_wdt_flag_pulse: assert property (p_wdt_flags) // see R10
        else $error("Watchdog opcode flags missing");

    // Timeout enters the shared reset sequence
    property p_wdt_reset;
        @(posedge pclk) disable iff (!presetn)
        wdt_timeout |=> s_reset_entry;
    endproperty
    a_wdt_timeout_reset: assert property (p_wdt_reset) // see R09
        else $error("Watchdog timeout gave no reset");

    // Software watchdog frozen in STOP
    property p_stop_wdt;
        @(posedge pclk) disable iff (!presetn)
        ((state_reg == swo_pkg::SWO_STOP) && !opt_reg[`SWO_OPT_PERMWDT]) |=>
            $stable(wdt_cnt_reg);
    endproperty
    a_stop_wdt_hold: assert property (p_stop_wdt) // see R11
        else $error("Watchdog counted in STOP");

    // Watchdog paused in HALT unless kept running
    property p_halt_wdt;
        @(posedge pclk) disable iff (!presetn)
        ((state_reg == swo_pkg::SWO_HALT) && !wdh_reg && !opt_reg[`SWO_OPT_PERMWDT]) |=>
            $stable(wdt_cnt_reg);
    endproperty
    a_halt_wdt_pause: assert property (p_halt_wdt) // see R12
        else $error("Watchdog counted in HALT");

    // Keep-in-halt needs an enabled watchdog
    property p_wdh_gate;
        @(posedge pclk) disable iff (!presetn)
        !wdt_en_reg |-> !wdh_reg;
    endproperty
    a_wdh_needs_wdt: assert property (p_wdh_gate) // see R13
        else $error("Keep-in-halt set without watchdog");

    // Test-disable blocks the programming data-out enable and write strobe
    property p_prog_block;
        @(posedge pclk) disable iff (!presetn)
        opt_reg[`SWO_OPT_TESTDIS] |=> (!prog_data_out_en && !prog_write_strobe);
    endproperty
    a_prog_blocked: assert property (p_prog_block) // see R18
        else $error("Programming active with test disable");

    // Clear pin zeroes the address counter
    property p_addr_clear;
        @(posedge pclk) disable iff (!presetn)
        clr_s[1] |=> (prog_addr == `SWO_ADDR_ZERO);
    endproperty
    a_addr_clear_zero: assert property (p_addr_clear) // see R22
        else $error("Address counter not cleared");

endmodule

// *** dv/swo_partner.sv ***
// Instruction stream and option programmer model facing the control block
module swo_partner (
    input wire logic pclk,
    output logic op_valid = 1'h0,
    output logic [7:0] op_code = 8'h00,
    output logic irq_taken = 1'h0,
    output logic stop_recovery_pin = 1'h1,
    output logic oscillator_input_hv = 1'h0,
    output logic port3_bit1 = 1'h1,
    output logic port3_bit2 = 1'h0,
    output logic program_mode_select_hv = 1'h0,
    output logic port3_bit3 = 1'h0,
    output logic port0_bit2 = 1'h1,
    output logic oscillator_input_pin = 1'h1,
    output logic clear_pin = 1'h0,
    output logic address_clock_pin = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sleep opcodes get a pipeline flush first; released code lines show junk
    task automatic issue(input logic [7:0] op, input logic nop_first);
        @(posedge pclk);
        if (nop_first) begin
            op_valid <= 1'h1;
            op_code <= 8'hFF;
            @(posedge pclk);
        end
        op_valid <= 1'h1;
        op_code <= op;
        @(posedge pclk);
        op_valid <= 1'h0;
        op_code <= ~op;
    endtask
    task automatic take_irq();
        @(posedge pclk);
        irq_taken <= 1'h1;
        @(posedge pclk);
        irq_taken <= 1'h0;
    endtask
    task automatic wake_pin();
        @(posedge pclk);
        stop_recovery_pin <= 1'h0;
        repeat (5) @(posedge pclk);
        stop_recovery_pin <= 1'h1;
    endtask
    // Order: chip enable, mode-select high voltage, mode select, OE, VPP, strobe
    task automatic prog_pins(input logic [5:0] v);
        @(posedge pclk);
        {oscillator_input_pin, program_mode_select_hv, port3_bit2, port3_bit1, port3_bit3,
            port0_bit2} <= v;
        repeat (4) @(posedge pclk);
    endtask
    task automatic pulse_pin(input logic clr);
        @(posedge pclk);
        if (clr) clear_pin <= 1'h1;
        else address_clock_pin <= 1'h1;
        repeat (3) @(posedge pclk);
        clear_pin <= 1'h0;
        address_clock_pin <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask
    // Select bits: mode-select high voltage, mode-select level, output enable
    task automatic set_option(input logic [2:0] sel);
        @(posedge pclk);
        oscillator_input_hv <= 1'h1;
        program_mode_select_hv <= sel[2];
        port3_bit2 <= sel[1];
        port3_bit1 <= sel[0];
        port3_bit3 <= 1'h1;
        port0_bit2 <= 1'h0;
        repeat (6) @(posedge pclk);
        port0_bit2 <= 1'h1;
        port3_bit3 <= 1'h0;
        oscillator_input_hv <= 1'h0;
        program_mode_select_hv <= 1'h0;
        @(posedge pclk);
    endtask
endmodule

// *** dv/sleep_watchdog_option_control_tb_top.sv ***
// Self-checking bench for the sleep, watchdog and option control block
`include "swo_cfg.svh"
module sleep_watchdog_option_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WDT = 50;
    localparam int POR = 10;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, op_valid, irq_taken, stop_recovery_pin, oscillator_input_hv;
    logic port3_bit1, port3_bit2, program_mode_select_hv, port3_bit3, port0_bit2;
    logic cpu_clk_en, osc_en, cpu_reset, keep_port_modes, flag_set_z, flag_clr_sv;
    logic clk_div_two, auto_latch_en, ext_read_block, prog_data_out_en, prog_write_strobe;
    logic [7:0] op_code;
    logic oscillator_input_pin, clear_pin, address_clock_pin;
    logic [15:0] fetch_vector;
    logic kpm_seen = 1'h0;
    logic [2:0] opt_sel [4] = '{3'h7, 3'h3, 3'h2, 3'h1};
    int fail_count = 0;
    int n_checks = 0;
    int z_seen = 0;
    int n, n_por;
    always #5 pclk = ~pclk;
    swo_core #(.WDT_CYCLES(WDT), .POR_CYCLES(POR)) dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_code, .irq_taken,
        .stop_recovery_pin, .oscillator_input_pin, .oscillator_input_hv, .port3_bit1,
        .port3_bit2, .program_mode_select_hv, .port3_bit3, .port0_bit2, .clear_pin,
        .address_clock_pin, .cpu_clk_en, .osc_en, .cpu_reset, .keep_port_modes,
        .fetch_vector, .flag_set_z, .flag_clr_sv, .clk_div_two, .auto_latch_en,
        .ext_read_block, .prog_addr(), .prog_data_out_en, .prog_write_strobe);
    swo_partner u_p (.pclk, .op_valid, .op_code, .irq_taken, .stop_recovery_pin,
        .oscillator_input_hv, .port3_bit1, .port3_bit2, .program_mode_select_hv, .port3_bit3,
        .port0_bit2, .oscillator_input_pin, .clear_pin, .address_clock_pin);
    always @(posedge pclk) begin
        if (flag_set_z === 1'h1 && flag_clr_sv === 1'h1) z_seen <= z_seen + 1;
        if (keep_port_modes === 1'h1) kpm_seen <= 1'h1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'hFFFFFFFF;
        @(posedge pclk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic wait_rst(input logic v);
        n = 0;
        while (cpu_reset !== v && n < 300) begin
            @(posedge pclk);
            n++;
        end
        if (n == 300) begin
            fail_count++;
            end_of_test();
        end
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        wait_rst(1'h0);
        n_por = n;
        check(fetch_vector, `SWO_RESET_VECTOR);
        check({cpu_clk_en, osc_en, clk_div_two, auto_latch_en, ext_read_block}, 5'h1E);
        apb(1'h0, 12'h020);
        check(err, 1'h1);
        apb(1'h1, `SWO_REG_CTRL);
        u_p.issue(`SWO_OP_WDH, 1'h0);
        apb(1'h0, `SWO_REG_CTRL);
        check(rd[2:0], 3'h0);
        u_p.issue(`SWO_OP_WDT, 1'h0);
        apb(1'h0, `SWO_REG_CTRL);
        check(rd[2:0], 3'h2);
        repeat (2) begin
            repeat (30) @(posedge pclk);
            u_p.issue(`SWO_OP_WDT, 1'h0);
        end
        repeat (3) @(posedge pclk);
        check(cpu_reset, 1'h0);
        check(z_seen, 3);
        wait_rst(1'h1);
        check(n >= WDT - 8 && n <= WDT + 5, 1'h1);
        wait_rst(1'h0);
        check(n, POR + `SWO_POR_EXTRA_CLKS);
        check(n_por, POR + `SWO_POR_EXTRA_CLKS + 2);
        check(n >= POR + `SWO_POR_EXTRA_CLKS, 1'h1);
        apb(1'h0, `SWO_REG_CTRL);
        check({kpm_seen, rd[2:0]}, 4'h0);
        u_p.issue(`SWO_OP_WDT, 1'h0);
        u_p.issue(`SWO_OP_HALT, 1'h1);
        repeat (3) @(posedge pclk);
        check({cpu_clk_en, osc_en}, 2'h1);
        repeat (80) @(posedge pclk);
        check(cpu_reset, 1'h0);
        u_p.take_irq();
        repeat (3) @(posedge pclk);
        check(cpu_clk_en, 1'h1);
        u_p.issue(`SWO_OP_STOP, 1'h1);
        repeat (3) @(posedge pclk);
        check({cpu_clk_en, osc_en}, 2'h0);
        repeat (80) @(posedge pclk);
        check(cpu_reset, 1'h0);
        u_p.wake_pin();
        wait_rst(1'h1);
        wait_rst(1'h0);
        check(kpm_seen, 1'h1);
        check(fetch_vector, `SWO_RESET_VECTOR);
        u_p.issue(`SWO_OP_WDT, 1'h0);
        u_p.issue(`SWO_OP_WDH, 1'h0);
        apb(1'h0, `SWO_REG_CTRL);
        check(rd[2:1], 2'h3);
        u_p.issue(`SWO_OP_HALT, 1'h1);
        wait_rst(1'h1);
        check(n <= WDT, 1'h1);
        wait_rst(1'h0);
        u_p.prog_pins(6'h11);
        check({prog_data_out_en, prog_write_strobe}, 2'h2);
        u_p.prog_pins(6'h0E);
        check({prog_data_out_en, prog_write_strobe}, 2'h1);
        u_p.prog_pins(6'h03);
        check({prog_data_out_en, prog_write_strobe}, 2'h2);
        u_p.prog_pins(6'h25);
        check({prog_data_out_en, prog_write_strobe}, 2'h0);
        repeat (3) u_p.pulse_pin(1'h0);
        apb(1'h0, `SWO_REG_PADDR);
        check(rd, 32'h00000003);
        u_p.pulse_pin(1'h1);
        apb(1'h0, `SWO_REG_PADDR);
        check(rd, 32'h00000000);
        foreach (opt_sel[i]) u_p.set_option(opt_sel[i]);
        apb(1'h0, `SWO_REG_OPT);
        check(rd[9:0], 10'h1E0);
        u_p.issue(`SWO_OP_WDT, 1'h0);
        wait_rst(1'h1);
        wait_rst(1'h0);
        check({clk_div_two, auto_latch_en, ext_read_block}, 3'h1);
        apb(1'h0, `SWO_REG_CTRL);
        check(rd[1], 1'h1);
        u_p.issue(`SWO_OP_STOP, 1'h1);
        wait_rst(1'h1);
        check(n <= WDT + 5, 1'h1);
        u_p.set_option(3'h0);
        wait_rst(1'h0);
        u_p.prog_pins(6'h03);
        check({prog_data_out_en, prog_write_strobe}, 2'h0);
        end_of_test();
    end
endmodule
